//--- rtl/wmf_pkg.sv
// Constants, types and field layouts of the weigh module ASCII link formatter.
// Assumes byte-wide receive and transmit streams and one 40 MHz clock.
// Notes on behaviour
// - System error replaces weight with error code.
// - Error field is ten characters wide.
// - Left spaces, Error, number, trigger character.
// - Fixed error number encoding per fault.
// - Trigger b for electronics, t terminal.
// - Commands and replies end with CR LF.
// - Backslash quote inside string is literal.
// - Multi-selection value is bitmask, 0 to 255.
// - Beyond fine range, tenth character is space.
// - Store config in terminal if attached.
// - Terminal removed: load bridge default config.
// - Terminal added: load terminal's stored config.
// - Changed parameters written to nonvolatile storage.
// - Every command received while no reply is owed gets a response; others are dropped.
// - Syntax, transmission, logical error two-letter replies.
package wmf_pkg;
   // ==========================================================
   // Characters
   localparam logic [7:0] CH_CR   = 8'h0d;
   localparam logic [7:0] CH_LF   = 8'h0a;
   localparam logic [7:0] CH_SP   = 8'h20;
   localparam logic [7:0] CH_QT   = 8'h22;
   localparam logic [7:0] CH_BS   = 8'h5c;
   localparam logic [7:0] CH_AT   = 8'h40;
   localparam logic [7:0] CH_0    = 8'h30;
   localparam logic [7:0] CH_9    = 8'h39;
   localparam logic [7:0] CH_1    = 8'h31;
   localparam logic [7:0] CH_UE   = 8'h45;
   localparam logic [7:0] CH_US   = 8'h53;
   localparam logic [7:0] CH_UT   = 8'h54;
   localparam logic [7:0] CH_UL   = 8'h4c;
   localparam logic [7:0] CH_R    = 8'h72;
   localparam logic [7:0] CH_O    = 8'h6f;
   localparam logic [7:0] CH_B    = 8'h62;
   localparam logic [7:0] CH_T    = 8'h74;
   // ==========================================================
   // Sizes and limits
   localparam int          FIFO_W     = 8;
   localparam int          FIFO_DEPTH = 32;
   localparam logic [6:0]  LINE_MAX   = 7'h40;   // Longest accepted line
   localparam logic [8:0]  MASK_MAX   = 9'h0ff;  // Highest multi-selection value
   localparam logic [8:0]  VAL_SAT    = 9'h1ff;
   localparam logic [4:0]  LEN_WEIGHT = 5'h11;   // id sp status sp field cr lf
   localparam logic [4:0]  LEN_STATUS = 5'h06;   // id sp status cr lf
   localparam logic [4:0]  LEN_SHORT  = 5'h04;   // two letters cr lf
   localparam logic [4:0]  LEN_NONE   = 5'h00;
   // ==========================================================
   // Error numbers on the weight field
   localparam logic [3:0] ERR_BOOT     = 4'h1;
   localparam logic [3:0] ERR_BRAND    = 4'h2;
   localparam logic [3:0] ERR_CHECKSUM = 4'h3;
   localparam logic [3:0] ERR_OPTION   = 4'h9;
   localparam logic [3:0] ERR_NVMEM    = 4'ha;
   localparam logic [3:0] ERR_MISMATCH = 4'hb;
   localparam logic [3:0] ERR_UNPLUG   = 4'hc;
   localparam logic [3:0] ERR_MOD_ELEC = 4'he;
   localparam logic [3:0] ERR_ADJUST   = 4'hf;
   localparam logic [3:0] ERR_TWO_DIG  = 4'ha;   // From here two digits
   // ==========================================================
   // Types
   typedef enum logic [0:0] {RK_WEIGHT, RK_STATUS} wmf_rkind_t;
   typedef enum logic [1:0] {IR_NONE, IR_SYNTAX, IR_TRANS, IR_LOGIC} wmf_ireply_t;
   typedef logic [0:16][7:0] wmf_msg_t;
   typedef struct packed {
      wmf_rkind_t  kind;
      logic [15:0] id;           // Two reply identifier characters
      logic [7:0]  status;
      logic [79:0] field;        // Ten weight characters, first at top
      logic        beyond_fine;
   } wmf_resp_t;
   typedef struct packed {
      logic [31:0] name;         // First four characters, first at top
      logic [6:0]  len;
      logic [7:0]  mask;         // First numeric parameter
      logic        has_num;
      logic        quoted;
   } wmf_cmd_t;
   typedef struct packed {
      logic       active;
      logic [3:0] num;
      logic       from_term;
   } wmf_err_t;
endpackage

//--- rtl/wmf_top.sv
// Receive line assembler, reply formatter, output FIFO and config store select.
// Assumes a command core answering CMD with RESP and a UART around RX and TX.
`timescale 1ns/10ps

// ==========================================================
// Byte FIFO between formatter and transmitter
module wmf_fifo #(
   parameter int W     = wmf_pkg::FIFO_W,
   parameter int DEPTH = wmf_pkg::FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [0:DEPTH-1];
   logic [AW:0]  wr_reg;
   logic [AW:0]  rd_reg;
   wire          full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   wire          empty = (wr_reg == rd_reg);
   wire          push  = in_valid && !full;
   wire          pop   = out_ready && !empty;

   // Handshake and head data
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop)  rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule

// ==========================================================
// Top of the link formatter
module wmf_top (
   input  wire logic             CLOCK,
   input  wire logic             RST,
   input  wire logic [7:0]       RX_DATA,
   input  wire logic             RX_VALID,
   input  wire logic             RX_FAULT,
   output logic                  RX_READY,
   output wmf_pkg::wmf_cmd_t     CMD,
   output logic                  CMD_VALID,
   input  wire wmf_pkg::wmf_resp_t RESP,
   input  wire logic             RESP_VALID,
   output logic                  RESP_READY,
   input  wire wmf_pkg::wmf_err_t SYS_ERR,
   output logic [7:0]            TX_DATA,
   output logic                  TX_VALID,
   input  wire logic             TX_READY,
   input  wire logic             TERM_PRESENT,
   input  wire logic             PARAM_CHANGED,
   output logic                  CFG_FROM_TERM,
   output logic                  CFG_LOAD,
   output logic                  NV_WRITE,
   output logic                  NV_TO_TERM
);
   typedef enum {ST_IDLE, ST_SEND} wmf_state_t;

   // ==========================================================
   // Error field builder
   function automatic logic [79:0] err_field(input wmf_pkg::wmf_err_t e);
      logic [7:0] trig;
      logic [7:0] lo;
      logic       two;
      trig = e.from_term ? wmf_pkg::CH_T : wmf_pkg::CH_B;
      two  = (e.num >= wmf_pkg::ERR_TWO_DIG);
      lo   = two ? (wmf_pkg::CH_0 + {4'h0, e.num - wmf_pkg::ERR_TWO_DIG})
                 : (wmf_pkg::CH_0 + {4'h0, e.num});
      if (two) begin
         err_field = {wmf_pkg::CH_SP, wmf_pkg::CH_SP, wmf_pkg::CH_UE, wmf_pkg::CH_R,
                      wmf_pkg::CH_R, wmf_pkg::CH_O, wmf_pkg::CH_R, wmf_pkg::CH_1, lo, trig};
      end else begin
         err_field = {wmf_pkg::CH_SP, wmf_pkg::CH_SP, wmf_pkg::CH_SP, wmf_pkg::CH_UE,
                      wmf_pkg::CH_R, wmf_pkg::CH_R, wmf_pkg::CH_O, wmf_pkg::CH_R, lo, trig};
      end
   endfunction

   // ==========================================================
   // Line assembler state
   logic [6:0]  len_reg,   len_next;
   logic        inq_reg,   inq_next;
   logic        esc_reg,   esc_next;
   logic        cr_reg,    cr_next;
   logic        flt_reg,   flt_next;
   logic        ovf_reg,   ovf_next;
   logic        quo_reg,   quo_next;
   logic        sp_reg,    sp_next;
   logic        num_reg,   num_next;
   logic        nend_reg,  nend_next;
   logic [8:0]  val_reg,   val_next;
   logic [31:0] name_reg,  name_next;
   logic        done;
   logic        busy_reg;
   wmf_pkg::wmf_ireply_t ir_reg;
   wmf_pkg::wmf_cmd_t    cmd_reg;
   logic        cmd_v_reg;

   // Byte decode
   wire         rx_fire  = RX_VALID && RX_READY;
   wire         is_digit = (RX_DATA >= wmf_pkg::CH_0) && (RX_DATA <= wmf_pkg::CH_9);
   wire [12:0]  acc      = {4'h0, val_reg} * 13'h000a + {9'h000, RX_DATA[3:0]};
   wire [8:0]   acc_sat  = (acc > {4'h0, wmf_pkg::VAL_SAT}) ? wmf_pkg::VAL_SAT : acc[8:0];
   wire [1:0]   name_pos = len_reg[1:0];

   assign RX_READY = !cmd_v_reg;

   // Next state of the assembler
   always_comb begin
      len_next  = len_reg;
      inq_next  = inq_reg;
      esc_next  = esc_reg;
      cr_next   = cr_reg;
      flt_next  = flt_reg;
      ovf_next  = ovf_reg;
      quo_next  = quo_reg;
      sp_next   = sp_reg;
      num_next  = num_reg;
      nend_next = nend_reg;
      val_next  = val_reg;
      name_next = name_reg;
      done      = 1'b0;
      if (rx_fire) begin
         if (RX_DATA == wmf_pkg::CH_AT && !inq_reg) begin
            // Cancel restarts the line with the cancel character
            len_next  = 7'h01;
            name_next = {wmf_pkg::CH_AT, 24'h000000};
            {inq_next, esc_next, cr_next, flt_next, ovf_next} = 5'h00;
            {quo_next, sp_next, num_next, nend_next} = 4'h0;
            val_next  = 9'h000;
         end else if (cr_reg && RX_DATA == wmf_pkg::CH_LF) begin
            done      = 1'b1;
            len_next  = 7'h00;
            name_next = 32'h00000000;
            {inq_next, esc_next, cr_next, flt_next, ovf_next} = 5'h00;
            {quo_next, sp_next, num_next, nend_next} = 4'h0;
            val_next  = 9'h000;
         end else if (RX_DATA == wmf_pkg::CH_CR && !esc_reg) begin
            cr_next  = 1'b1;
            flt_next = flt_reg || RX_FAULT;
         end else begin
            cr_next  = 1'b0;
            flt_next = flt_reg || RX_FAULT;
            if (inq_reg) begin
               if (esc_reg) esc_next = 1'b0;
               else if (RX_DATA == wmf_pkg::CH_BS) esc_next = 1'b1;
               else if (RX_DATA == wmf_pkg::CH_QT) inq_next = 1'b0;
            end else if (RX_DATA == wmf_pkg::CH_QT) begin
               inq_next = 1'b1;
               quo_next = 1'b1;
            end else if (RX_DATA == wmf_pkg::CH_SP) begin
               sp_next   = 1'b1;
               nend_next = nend_reg || num_reg;
            end else if (is_digit && sp_reg && !nend_reg) begin
               num_next = 1'b1;
               val_next = acc_sat;
            end
            if (!sp_reg && len_reg < 7'h04 && RX_DATA != wmf_pkg::CH_SP) begin
               name_next[8'(31 - 8 * name_pos) -: 8] = RX_DATA;
            end
            if (len_reg == wmf_pkg::LINE_MAX) ovf_next = 1'b1;
            else len_next = len_reg + 7'h01;
         end
      end
   end

   // Classification of a finished line
   wire bad_syntax = ovf_reg || inq_reg || (len_reg == 7'h00);
   wire bad_mask   = num_reg && (val_reg > wmf_pkg::MASK_MAX);
   wire accept     = done && !busy_reg && (ir_reg == wmf_pkg::IR_NONE);
   wire [1:0] ir_new = flt_reg    ? wmf_pkg::IR_TRANS :
                       bad_syntax ? wmf_pkg::IR_SYNTAX :
                       bad_mask   ? wmf_pkg::IR_LOGIC  : wmf_pkg::IR_NONE;

   // Assembler registers
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         {len_reg, inq_reg, esc_reg, cr_reg, flt_reg, ovf_reg} <= '0;
         {quo_reg, sp_reg, num_reg, nend_reg, val_reg, name_reg} <= '0;
      end else begin
         {len_reg, inq_reg, esc_reg, cr_reg, flt_reg, ovf_reg} <=
            {len_next, inq_next, esc_next, cr_next, flt_next, ovf_next};
         {quo_reg, sp_reg, num_reg, nend_reg, val_reg, name_reg} <=
            {quo_next, sp_next, num_next, nend_next, val_next, name_next};
      end
   end

   // ==========================================================
   // Command dispatch and reply bookkeeping
   wmf_state_t  st_reg;
   wmf_pkg::wmf_msg_t msg_reg;
   logic [4:0]  mlen_reg;
   logic [4:0]  idx_reg;
   logic        fifo_rdy;
   wire         load_ir   = (st_reg == ST_IDLE) && (ir_reg != wmf_pkg::IR_NONE);
   wire         load_resp = RESP_VALID && RESP_READY;
   wire         sent_last = (st_reg == ST_SEND) && fifo_rdy && (idx_reg == mlen_reg - 5'h01);

   assign RESP_READY = (st_reg == ST_IDLE) && (ir_reg == wmf_pkg::IR_NONE);
   assign CMD        = cmd_reg;
   assign CMD_VALID  = cmd_v_reg;

   // Lines arriving while a reply is owed are dropped
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ir_reg    <= wmf_pkg::IR_NONE;
         busy_reg  <= 1'b0;
         cmd_v_reg <= 1'b0;
         cmd_reg   <= '0;
      end else begin
         cmd_v_reg <= accept && (ir_new == wmf_pkg::IR_NONE);
         if (accept && ir_new != wmf_pkg::IR_NONE) begin
            ir_reg <= wmf_pkg::wmf_ireply_t'(ir_new);
         end else if (load_ir) begin
            ir_reg <= wmf_pkg::IR_NONE;
         end
         if (accept && ir_new == wmf_pkg::IR_NONE) begin
            busy_reg <= 1'b1;
            cmd_reg  <= '{name: name_reg, len: len_reg, mask: val_reg[7:0],
                          has_num: num_reg, quoted: quo_reg};
         end else if (load_resp) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Reply message building
   wire [79:0] wfield   = SYS_ERR.active ? err_field(SYS_ERR) :
                          (RESP.beyond_fine ? {RESP.field[79:8], wmf_pkg::CH_SP}
                                            : RESP.field);
   wire [7:0]  ir_ch    = (ir_reg == wmf_pkg::IR_TRANS) ? wmf_pkg::CH_UT :
                          (ir_reg == wmf_pkg::IR_LOGIC) ? wmf_pkg::CH_UL : wmf_pkg::CH_US;
   wire wmf_pkg::wmf_msg_t m_weight = {RESP.id, wmf_pkg::CH_SP, RESP.status, wmf_pkg::CH_SP,
                                       wfield, wmf_pkg::CH_CR, wmf_pkg::CH_LF};
   wire wmf_pkg::wmf_msg_t m_status = {RESP.id, wmf_pkg::CH_SP, RESP.status,
                                       wmf_pkg::CH_CR, wmf_pkg::CH_LF, 88'h0};
   wire wmf_pkg::wmf_msg_t m_short  = {wmf_pkg::CH_UE, ir_ch, wmf_pkg::CH_CR,
                                       wmf_pkg::CH_LF, 104'h0};
   wire wmf_pkg::wmf_msg_t m_sel    = load_ir ? m_short :
                                      (RESP.kind == wmf_pkg::RK_WEIGHT) ? m_weight : m_status;
   wire [4:0]  l_sel    = load_ir ? wmf_pkg::LEN_SHORT :
                          (RESP.kind == wmf_pkg::RK_WEIGHT) ? wmf_pkg::LEN_WEIGHT
                                                            : wmf_pkg::LEN_STATUS;

   // Formatter sequencer, one byte per accepted FIFO slot
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_reg   <= ST_IDLE;
         msg_reg  <= '0;
         mlen_reg <= wmf_pkg::LEN_NONE;
         idx_reg  <= 5'h00;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               if (load_ir || load_resp) begin
                  msg_reg  <= m_sel;
                  mlen_reg <= l_sel;
                  idx_reg  <= 5'h00;
                  st_reg   <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (sent_last) st_reg <= ST_IDLE;
               else if (fifo_rdy) idx_reg <= idx_reg + 5'h01;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Transmit buffer
   wmf_fifo #(
      .W     (wmf_pkg::FIFO_W),
      .DEPTH (wmf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLOCK),
      .rst       (RST),
      .in_data   (msg_reg[idx_reg]),
      .in_valid  (st_reg == ST_SEND),
      .in_ready  (fifo_rdy),
      .out_data  (TX_DATA),
      .out_valid (TX_VALID),
      .out_ready (TX_READY)
   );

   // ==========================================================
   // Configuration store selection
   logic term_reg;
   logic load_reg;
   logic nvw_reg;

   assign CFG_FROM_TERM = term_reg;
   assign NV_TO_TERM    = term_reg;
   assign CFG_LOAD      = load_reg;
   assign NV_WRITE      = nvw_reg;

   // Attach loads terminal config, detach loads bridge default
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         term_reg <= 1'b0;
         load_reg <= 1'b0;
         nvw_reg  <= 1'b0;
      end else begin
         term_reg <= TERM_PRESENT;
         load_reg <= (TERM_PRESENT != term_reg);
         nvw_reg  <= PARAM_CHANGED;
      end
   end
endmodule

//--- tb/wmf_checker.sv
// Port checks for the link formatter top.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/10ps

// ==========================================================
// Checker
module wmf_checker (
   input wire logic               CLOCK,
   input wire logic               RST,
   input wire logic [7:0]         RX_DATA,
   input wire logic               RX_VALID,
   input wire logic               RX_READY,
   input wire logic               CMD_VALID,
   input wire wmf_pkg::wmf_resp_t RESP,
   input wire logic               RESP_VALID,
   input wire logic               RESP_READY,
   input wire logic [7:0]         TX_DATA,
   input wire logic               TX_VALID,
   input wire logic               TX_READY,
   input wire logic               TERM_PRESENT,
   input wire logic               PARAM_CHANGED,
   input wire logic               CFG_FROM_TERM,
   input wire logic               CFG_LOAD,
   input wire logic               NV_WRITE,
   input wire logic               NV_TO_TERM
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   // Reply taken and end of line leaving
   wire logic take = RESP_VALID && RESP_READY;
   sequence cr_pop_s;
      TX_VALID && TX_READY && TX_DATA == wmf_pkg::CH_CR;
   endsequence
   sequence busy_s;
      !RESP_READY [*5];
   endsequence
   chk_cfg_follow: assert property (!$past(RST) |-> CFG_FROM_TERM == $past(TERM_PRESENT))
      else $error("config source does not follow terminal");
   chk_store_same: assert property (NV_TO_TERM == CFG_FROM_TERM)
      else $error("store target differs from config source");
   chk_load_cause: assert property (CFG_LOAD |-> CFG_FROM_TERM != $past(CFG_FROM_TERM))
      else $error("config load without presence change");
   chk_load_on_swap: assert property (!$past(RST) && $changed(TERM_PRESENT) |=> CFG_LOAD)
      else $error("presence change without config load");
   chk_nv_write: assert property (!$past(RST) |-> NV_WRITE == $past(PARAM_CHANGED))
      else $error("parameter change not written");
   chk_rx_block: assert property (RX_READY == !CMD_VALID)
      else $error("receive ready wrong around dispatch");
   chk_cmd_cause: assert property (CMD_VALID |-> $past(RX_DATA) == wmf_pkg::CH_LF && $past(RX_DATA, 2) == wmf_pkg::CH_CR)
      else $error("command without line end");
   chk_reply_busy: assert property (take |=> busy_s)
      else $error("formatter took reply while sending");
   chk_reply_first: assert property (take && !TX_VALID |-> ##2 TX_VALID && TX_DATA == $past(RESP.id[15:8], 2))
      else $error("reply does not start with its id");
   chk_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("transmit byte lost while stalled");
   chk_crlf_tail: assert property (cr_pop_s |=> !TX_VALID || TX_DATA == wmf_pkg::CH_LF)
      else $error("carriage return not followed by line feed");
endmodule

bind wmf_top wmf_checker chk_u (.*);

//--- tb/wmf_host_model.sv
// Host side model: sends command lines and collects reply bytes.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps

// ==========================================================
// Host model
module wmf_host_model (
   input  wire logic       clk,
   input  wire logic       rx_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       stall,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            rx_fault,
   output logic            tx_ready
);
   logic [7:0] got_q[$];
   int         timeouts = 0;
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_fault = 1'b0;
   end
   // Reply bytes are popped unless the host stalls
   assign tx_ready = !stall;
   always @(posedge clk) begin
      if (tx_valid && tx_ready) got_q.push_back(tx_data);
   end
   // One byte held until taken
   task automatic put_byte(input logic [7:0] b, input logic f);
      int n;
      rx_data <= b;
      rx_valid <= 1'b1;
      rx_fault <= f;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rx_ready !== 1'b1 && n < 50);
      if (n >= 50) timeouts++;
   endtask
   // Whole line, quotes kept as given, closed by CR LF
   task automatic send_line(input string s, input int bad);
      @(posedge clk);
      for (int i = 0; i < s.len(); i++) put_byte(s[i], i == bad);
      put_byte(8'h0d, 1'b0);
      put_byte(8'h0a, 1'b0);
      rx_valid <= 1'b0;
      rx_data <= 8'hf5; // Inverse of the last byte
      rx_fault <= 1'b0;
   endtask
endmodule

//--- tb/test_weigh_module_ascii_response_formatter.sv
// Self-checking bench for the link formatter top.
// Assumes the host model on the stream side and the bench as command core.
`timescale 1ns/10ps

// ==========================================================
// Bench top
module test_weigh_module_ascii_response_formatter;
   typedef struct {
      string      cmd;
      int         bad;      // Faulty byte position, -1 for none
      logic       weight;
      logic       err;
      logic [3:0] num;
      logic       term;
      logic       coarse;
      string      exp;      // Internal reply letter, empty for core reply
   } wmf_row_t;
   logic               CLOCK = 1'b0;
   logic               RST = 1'b1;
   logic [7:0]         RX_DATA;
   logic               RX_VALID;
   logic               RX_FAULT;
   logic               RX_READY;
   wmf_pkg::wmf_cmd_t  CMD;
   logic               CMD_VALID;
   wmf_pkg::wmf_resp_t RESP = '0;
   logic               RESP_VALID = 1'b0;
   logic               RESP_READY;
   wmf_pkg::wmf_err_t  SYS_ERR = '0;
   logic [7:0]         TX_DATA;
   logic               TX_VALID;
   logic               TX_READY;
   logic               TERM_PRESENT = 1'b1;
   logic               PARAM_CHANGED = 1'b0;
   logic               CFG_FROM_TERM;
   logic               CFG_LOAD;
   logic               NV_WRITE;
   logic               NV_TO_TERM;
   logic               stall = 1'b0;
   int                 mismatches = 0;
   int                 compares = 0;
   wmf_row_t           rows[$];
   logic [3:0]         codes[9] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
   logic [7:0]         masks[4] = '{8'h00, 8'h01, 8'h80, 8'hff};
   wmf_row_t           w = '{"SI", -1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, ""};
   logic               saw;

   always #12.5 CLOCK = ~CLOCK;

   wmf_top dut_u (.*);
   wmf_host_model host_u (.clk(CLOCK), .rx_ready(RX_READY), .tx_data(TX_DATA),
      .tx_valid(TX_VALID), .stall(stall), .rx_data(RX_DATA), .rx_valid(RX_VALID),
      .rx_fault(RX_FAULT), .tx_ready(TX_READY));

   // ==========================================================
   // Reporting
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic report(string m);
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic bound(int n, int lim);
      if (n >= lim || host_u.timeouts != 0) begin
         report("wait ran out");
         finish_test;
      end
   endtask
   task automatic cmp_bit(logic g, logic e, string m);
      compares++;
      if (g !== e) report(m);
   endtask
   task automatic cmp_vec(logic [31:0] g, logic [31:0] e, string m);
      compares++;
      if (g !== e) report(m);
   endtask
   task automatic check_reply(string e);
      int n;
      n = 0;
      while (host_u.got_q.size() < e.len() && n < 400) begin
         @(posedge CLOCK);
         n++;
      end
      bound(n, 400);
      repeat (4) @(posedge CLOCK);
      compares++;
      if (host_u.got_q.size() != e.len()) report("reply length");
      else foreach (host_u.got_q[i]) if (host_u.got_q[i] !== e[i]) report("reply byte");
   endtask

   // ==========================================================
   // Core side reply and expected text
   function automatic string expect_str(wmf_row_t r);
      string f;
      if (r.exp != "") return {"E", r.exp, "\r\n"};
      if (!r.weight) return "SI S\r\n";
      f = r.coarse ? "    12.34 " : "    12.345";
      if (r.err) f = $sformatf("Error%0d%s", r.num, r.term ? "t" : "b");
      while (f.len() < 10) f = {" ", f};
      return {"SI S ", f, "\r\n"};
   endfunction
   task automatic give_resp(wmf_row_t r);
      wmf_pkg::wmf_resp_t rv;
      int n;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (CMD_VALID !== 1'b1 && n < 40);
      bound(n, 40);
      rv.kind = r.weight ? wmf_pkg::RK_WEIGHT : wmf_pkg::RK_STATUS;
      rv.id = "SI";
      rv.status = "S";
      rv.field = "    12.345";
      rv.beyond_fine = r.coarse;
      RESP <= rv;
      RESP_VALID <= 1'b1;
      SYS_ERR <= '{r.err, r.num, r.term};
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (RESP_READY !== 1'b1 && n < 60);
      RESP <= ~rv;
      RESP_VALID <= 1'b0;
      bound(n, 60);
   endtask
   task automatic run_row(wmf_row_t r);
      host_u.got_q.delete();
      host_u.send_line(r.cmd, r.bad);
      if (r.exp == "") give_resp(r);
      check_reply(expect_str(r));
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      #2500000;
      report("run too long");
      finish_test;
   end
   initial begin
      repeat (12) @(posedge CLOCK);
      cmp_bit(TX_VALID, 1'b0, "reset transmit valid");
      cmp_bit(RESP_READY, 1'b1, "reset reply ready");
      RST <= 1'b0;
      rows.push_back('{"@", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, ""});
      foreach (codes[i]) rows.push_back('{"SI", -1, 1'b1, 1'b1, codes[i], i[0], 1'b0, ""});
      rows.push_back(w);
      rows.push_back('{"SI", -1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, ""});
      rows.push_back('{"D \"a\\\"b\"", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, ""});
      rows.push_back('{"D \"ab", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, "S"});
      rows.push_back('{"", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, "S"});
      rows.push_back('{{65{"A"}}, -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, "S"});
      rows.push_back('{"SI", 1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, "T"});
      rows.push_back('{"M 256", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, "L"});
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      // Selection bitmask at its boundaries
      foreach (masks[i]) begin
         run_row('{$sformatf("M %0d", masks[i]), -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, ""});
         cmp_vec({24'h0, CMD.mask}, {24'h0, masks[i]}, "selection mask");
         cmp_bit(CMD.has_num, 1'b1, "number flag");
      end
      $display("mask test done");
      // Cancel inside a line restarts it
      run_row('{"QQ@", -1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, ""});
      cmp_vec(CMD.name, 32'h40000000, "restart name");
      cmp_vec({25'h0, CMD.len}, 32'h1, "restart length");
      $display("cancel test done");
      // Two weight replies into a stalled buffer
      host_u.got_q.delete();
      stall <= 1'b1;
      host_u.send_line("SI", -1);
      give_resp(w);
      host_u.send_line("SI", -1);
      give_resp(w);
      repeat (40) @(posedge CLOCK);
      cmp_bit(RESP_READY, 1'b0, "full buffer not holding formatter");
      stall <= 1'b0;
      check_reply({expect_str(w), expect_str(w)});
      $display("buffer test done");
      // Terminal detach and attach, then a parameter change
      for (int t = 0; t < 3; t++) begin
         @(posedge CLOCK);
         TERM_PRESENT <= t[0];
         PARAM_CHANGED <= t[1];
         saw = 1'b0;
         @(posedge CLOCK);
         PARAM_CHANGED <= 1'b0;
         repeat (3) begin
            #1;
            saw = saw | (t[1] ? NV_WRITE : CFG_LOAD);
            @(posedge CLOCK);
         end
         cmp_bit(saw, 1'b1, "load or write pulse missing");
         cmp_bit(CFG_FROM_TERM, t[0], "config source");
         cmp_bit(NV_TO_TERM, t[0], "store target");
      end
      $display("config test done");
      finish_test;
   end
endmodule
